// ### verilog/ivp_irq_top.sv
// interrupt vector, source mirror and read acknowledge logic behind the die link
module ivp_irq_top (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // die-to-die link read access, asynchronous pins
    input wire logic link_clk,
    input wire logic link_rd,
    input wire logic [ivp_pkg::IVP_ADDR_W-1:0] link_addr,
    output logic [ivp_pkg::IVP_DATA_W-1:0] link_rd_data,
    output logic link_rd_valid,
    // interrupt line to the host
    output logic die_link_interrupt_out,
    // power mode, same clock
    input wire logic stop_mode,
    input wire logic wake_event,
    // analog conditions, asynchronous levels
    input wire logic regulator_low_voltage_irq,
    input wire logic regulator_high_temp_irq,
    input wire logic low_battery_irq,
    input wire logic high_voltage_irq,
    input wire logic regulator_overvoltage_irq,
    input wire logic transceiver_overtemp_irq,
    input wire logic high_side_overtemp_irq,
    input wire logic low_side_overtemp_irq,
    input wire logic sensor_supply_overtemp_irq,
    // peripheral pending flags, same clock, owned elsewhere
    input wire logic [3:0] timer_channel_irq,
    input wire logic timer_overflow_irq,
    input wire logic sci_error_irq,
    input wire logic sci_transmit_irq,
    input wire logic sci_receive_irq,
    input wire logic converter_sequence_done_irq
);

    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_prev;
        logic rd_s1;
        logic rd_s2;
        logic [ivp_pkg::IVP_ADDR_W-1:0] addr_s1;
        logic [ivp_pkg::IVP_ADDR_W-1:0] addr_s2;
        logic [ivp_pkg::IVP_DATA_W-1:0] rd_data;
        logic rd_valid;
        logic wake;
        logic irq;
    } ivp_top_state_t;

    ivp_top_state_t st_r;
    ivp_top_state_t st_nxt;

    logic [ivp_pkg::IVP_NUM_CELLS-1:0] cond_vec;
    logic [ivp_pkg::IVP_NUM_CELLS-1:0] ack_vec;
    logic [ivp_pkg::IVP_NUM_CELLS-1:0] cell_pend;
    logic [ivp_pkg::IVP_NUM_CELLS-1:0] cell_rise;
    logic [ivp_pkg::IVP_NUM_PRIO-1:0] prio_vec;
    logic [ivp_pkg::IVP_DATA_W-1:0] isr_val;
    logic [ivp_pkg::IVP_DATA_W-1:0] rd_mux;
    logic [5:0] vec_code;
    logic [7:0] off;
    logic take;
    logic win_blk;
    logic win_nb;
    logic hit;
    logic combined_voltage_interrupt;
    logic any_pend;

    ////////////////////////////////////////////////////////////////////////////////
    // analog sources: each one latches on a rising condition edge
    assign cond_vec = {
        sensor_supply_overtemp_irq,
        low_side_overtemp_irq,
        high_side_overtemp_irq,
        transceiver_overtemp_irq,
        regulator_overvoltage_irq,
        high_voltage_irq,
        low_battery_irq,
        regulator_high_temp_irq,
        regulator_low_voltage_irq
    };

    for (genvar g = 0; g < ivp_pkg::IVP_NUM_CELLS; g++)
    begin : g_src
        ivp_edge_src u_src (
            .clk(clk),
            .rstn(rstn),
            .cond(cond_vec[g]),
            .ack(ack_vec[g]),
            .pend(cell_pend[g]),
            .rise(cell_rise[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // priority order, bit 0 ranks highest; peripheral flags are only looked at
    assign prio_vec = {
        cell_pend[ivp_pkg::IVP_CELL_REGULATOR_OVERVOLTAGE_IRQ],  // lowest
        cell_pend[ivp_pkg::IVP_CELL_HVI],
        cell_pend[ivp_pkg::IVP_CELL_HOT],
        cell_pend[ivp_pkg::IVP_CELL_LOW_SIDE_OVERTEMP_IRQ],
        cell_pend[ivp_pkg::IVP_CELL_HIGH_SIDE_OVERTEMP_IRQ],
        cell_pend[ivp_pkg::IVP_CELL_TRANSCEIVER_OVERTEMP_IRQ],
        converter_sequence_done_irq,
        sci_receive_irq,
        sci_transmit_irq,
        sci_error_irq,
        timer_overflow_irq,
        timer_channel_irq,                    // and
        cell_pend[ivp_pkg::IVP_CELL_LBI],
        cell_pend[ivp_pkg::IVP_CELL_HTI],
        cell_pend[ivp_pkg::IVP_CELL_LVI]
    };

    ivp_prio_enc #(
        .NUM(ivp_pkg::IVP_NUM_PRIO)
    ) u_enc (
        .pend(prio_vec),
        .code(vec_code)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // source mirror: combined voltage bit plus every other source
    assign combined_voltage_interrupt = |(cell_pend & ivp_pkg::IVP_VSR_CELLS);

    always_comb
    begin
        isr_val = '0;
        isr_val[ivp_pkg::IVP_ISR_VSI] = combined_voltage_interrupt;
        isr_val[ivp_pkg::IVP_ISR_CH0 +: 4] = timer_channel_irq;
        isr_val[ivp_pkg::IVP_ISR_TOV] = timer_overflow_irq;
        isr_val[ivp_pkg::IVP_ISR_ERR] = sci_error_irq;
        isr_val[ivp_pkg::IVP_ISR_TX] = sci_transmit_irq;
        isr_val[ivp_pkg::IVP_ISR_RX] = sci_receive_irq;
        isr_val[ivp_pkg::IVP_ISR_ADC] = converter_sequence_done_irq;
        isr_val[ivp_pkg::IVP_ISR_TRANSCEIVER_OVERTEMP_IRQ] = cell_pend[ivp_pkg::IVP_CELL_TRANSCEIVER_OVERTEMP_IRQ];
        isr_val[ivp_pkg::IVP_ISR_HIGH_SIDE_OVERTEMP_IRQ] = cell_pend[ivp_pkg::IVP_CELL_HIGH_SIDE_OVERTEMP_IRQ];
        isr_val[ivp_pkg::IVP_ISR_LOW_SIDE_OVERTEMP_IRQ] = cell_pend[ivp_pkg::IVP_CELL_LOW_SIDE_OVERTEMP_IRQ];
        isr_val[ivp_pkg::IVP_ISR_HOT] = cell_pend[ivp_pkg::IVP_CELL_HOT];
    end

    assign any_pend = |prio_vec;

    ////////////////////////////////////////////////////////////////////////////////
    // link access: a read is taken on a rising edge of the synchronised link clock.
    // address and strobe are two-flop synchronised too; they must be stable around
    // the link clock edge, which the link protocol guarantees
    assign take = st_r.clk_s2 & ~st_r.clk_prev & st_r.rd_s2;
    assign win_blk = st_r.addr_s2[9:8] == ivp_pkg::IVP_BASE_BLK_ADDR[9:8];
    assign win_nb = st_r.addr_s2[9:8] == ivp_pkg::IVP_BASE_NB_ADDR[9:8];
    assign hit = win_blk | win_nb; // both windows alias
    assign off = st_r.addr_s2[7:0];

    // read acknowledges: one cycle pulse in the cycle the read is taken
    always_comb
    begin
        ack_vec = '0;
        if (take && hit)
        begin
            if (off == ivp_pkg::IVP_OFF_VSR)
                ack_vec = ivp_pkg::IVP_VSR_CELLS;
            else if (off == ivp_pkg::IVP_OFF_TRANSCEIVER_STATUS_REGISTER)
                ack_vec[ivp_pkg::IVP_CELL_TRANSCEIVER_OVERTEMP_IRQ] = 1'b1;
            else if (off == ivp_pkg::IVP_OFF_HIGH_SIDE_STATUS_REGISTER)
                ack_vec[ivp_pkg::IVP_CELL_HIGH_SIDE_OVERTEMP_IRQ] = 1'b1;
            else if (off == ivp_pkg::IVP_OFF_LOW_SIDE_STATUS_REGISTER)
                ack_vec[ivp_pkg::IVP_CELL_LOW_SIDE_OVERTEMP_IRQ] = 1'b1;
            else if (off == ivp_pkg::IVP_OFF_HSR)
                ack_vec[ivp_pkg::IVP_CELL_HOT] = 1'b1;
        end
    end

    // read data mux; mirror and vector reads cause no acknowledge
    always_comb
    begin
        rd_mux = '0;
        if (!hit)
            rd_mux = '0;
        else if (off == ivp_pkg::IVP_OFF_ISR)
            rd_mux = isr_val;
        else if (off == ivp_pkg::IVP_OFF_ISR_HI)
            rd_mux = {8'h00, isr_val[15:8]};
        else if (off == ivp_pkg::IVP_OFF_IVR)
            rd_mux = {10'h000, vec_code}; // upper bits zero, and
        else if (off == ivp_pkg::IVP_OFF_VSR)
            rd_mux = {11'h000, cell_pend[4:0]};
        else if (off == ivp_pkg::IVP_OFF_TRANSCEIVER_STATUS_REGISTER)
            rd_mux = {15'h0000, cell_pend[ivp_pkg::IVP_CELL_TRANSCEIVER_OVERTEMP_IRQ]};
        else if (off == ivp_pkg::IVP_OFF_HIGH_SIDE_STATUS_REGISTER)
            rd_mux = {15'h0000, cell_pend[ivp_pkg::IVP_CELL_HIGH_SIDE_OVERTEMP_IRQ]};
        else if (off == ivp_pkg::IVP_OFF_LOW_SIDE_STATUS_REGISTER)
            rd_mux = {15'h0000, cell_pend[ivp_pkg::IVP_CELL_LOW_SIDE_OVERTEMP_IRQ]};
        else if (off == ivp_pkg::IVP_OFF_HSR)
            rd_mux = {15'h0000, cell_pend[ivp_pkg::IVP_CELL_HOT]};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state: synchronisers, read data register, wake flag and interrupt line
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.clk_s1 = link_clk;
        st_nxt.clk_s2 = st_r.clk_s1;
        st_nxt.clk_prev = st_r.clk_s2;
        st_nxt.rd_s1 = link_rd;
        st_nxt.rd_s2 = st_r.rd_s1;
        st_nxt.addr_s1 = link_addr;
        st_nxt.addr_s2 = st_r.addr_s1;
        st_nxt.rd_valid = take;
        if (take)
            st_nxt.rd_data = rd_mux; // and
        // any link access acknowledges a wake-up; a new wake event wins over it
        if (take)
            st_nxt.wake = 1'b0;
        if (stop_mode && wake_event)
            st_nxt.wake = 1'b1;
        // stop mode lets only wake-up through
        if (stop_mode)
            st_nxt.irq = st_r.wake;
        else
            st_nxt.irq = any_pend | st_r.wake; // held until acknowledged
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_r <= '0;
            st_r.rd_data <= ivp_pkg::IVP_RD_RESET;
        end
        else
            st_r <= st_nxt;
    end

    assign link_rd_data = st_r.rd_data;
    assign link_rd_valid = st_r.rd_valid;
    assign die_link_interrupt_out = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_ivr_read;
        take && hit && off == ivp_pkg::IVP_OFF_IVR;
    endsequence

    sequence s_vsr_read;
        take && hit && off == ivp_pkg::IVP_OFF_VSR;
    endsequence

    ivr_code_read_a: assert property (s_ivr_read |=>
        link_rd_valid && link_rd_data == {10'h000, $past(vec_code)})
        else $error("vector read returned wrong code");

    ivr_upper_zero_a: assert property (s_ivr_read |=> link_rd_data[15:6] == 10'h000)
        else $error("vector upper bits not zero");

    ivr_idle_zero_a: assert property (s_ivr_read and (prio_vec == '0) |=>
        link_rd_data == {10'h000, ivp_pkg::IVP_IRQ_NONE})
        else $error("vector not zero when idle");

    ivr_no_clear_a: assert property (s_ivr_read |=>
        ($past(cell_pend) & ~cell_pend) == '0)
        else $error("vector read cleared a source");

    vsr_ack_clear_a: assert property (s_vsr_read |=>
        (cell_pend & ivp_pkg::IVP_VSR_CELLS & ~$past(cell_rise)) == '0)
        else $error("voltage status read left a supply source pending");

    top_rank_a: assert property (prio_vec[0] |-> vec_code == ivp_pkg::IVP_IRQ_LVI)
        else $error("low voltage not ranked first");

    tov_rank_a: assert property (prio_vec[7:0] == 8'h80 |->
        vec_code == ivp_pkg::IVP_IRQ_TOV)
        else $error("timer overflow code wrong");

    lowest_rank_a: assert property (prio_vec == 18'h20000 |->
        vec_code == ivp_pkg::IVP_IRQ_REGULATOR_OVERVOLTAGE_IRQ)
        else $error("over-voltage code wrong");

    vsi_or_a: assert property (isr_val[ivp_pkg::IVP_ISR_VSI] == |cell_pend[4:0])
        else $error("combined voltage bit wrong");

    stop_quiet_a: assert property (stop_mode && !st_r.wake |=>
        !die_link_interrupt_out)
        else $error("interrupt raised in stop mode without wake-up");

    irq_hold_a: assert property (!stop_mode && any_pend |=>
        die_link_interrupt_out)
        else $error("interrupt line dropped while a source pends");

endmodule : ivp_irq_top

// ### inc/ivp_pkg.sv
// constants for the interrupt vector, priority and acknowledge block
package ivp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int IVP_ADDR_W = 10;
    localparam int IVP_DATA_W = 16;
    localparam int IVP_CODE_W = 6;
    localparam int IVP_NUM_PRIO = 18;
    localparam int IVP_NUM_CELLS = 9;

    ////////////////////////////////////////////////////////////////////////////////
    // link windows and register offsets
    localparam logic [IVP_ADDR_W-1:0] IVP_BASE_BLK_ADDR = 10'h200;
    localparam logic [IVP_ADDR_W-1:0] IVP_BASE_NB_ADDR = 10'h300;
    localparam logic [7:0] IVP_OFF_ISR = 8'h00;
    localparam logic [7:0] IVP_OFF_ISR_HI = 8'h01;
    localparam logic [7:0] IVP_OFF_IVR = 8'h02;
    localparam logic [7:0] IVP_OFF_VSR = 8'h10;
    localparam logic [7:0] IVP_OFF_TRANSCEIVER_STATUS_REGISTER = 8'h11;
    localparam logic [7:0] IVP_OFF_HIGH_SIDE_STATUS_REGISTER = 8'h12;
    localparam logic [7:0] IVP_OFF_LOW_SIDE_STATUS_REGISTER = 8'h13;
    localparam logic [7:0] IVP_OFF_HSR = 8'h14;
    localparam logic [IVP_DATA_W-1:0] IVP_RD_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // vector codes
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_NONE = 6'h00;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_LVI = 6'h02;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_HTI = 6'h04;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_LBI = 6'h06;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_CH0 = 6'h08;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_CH3 = 6'h0E;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_TOV = 6'h10;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_ERR = 6'h12;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_ADC = 6'h18;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_TRANSCEIVER_OVERTEMP_IRQ = 6'h1A;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_HIGH_SIDE_OVERTEMP_IRQ = 6'h1C;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_HOT = 6'h20;
    localparam logic [IVP_CODE_W-1:0] IVP_IRQ_REGULATOR_OVERVOLTAGE_IRQ = 6'h24;

    ////////////////////////////////////////////////////////////////////////////////
    // source mirror bit positions
    localparam int IVP_ISR_VSI = 0;
    localparam int IVP_ISR_CH0 = 1;
    localparam int IVP_ISR_TOV = 5;
    localparam int IVP_ISR_ERR = 6;
    localparam int IVP_ISR_TX = 7;
    localparam int IVP_ISR_RX = 8;
    localparam int IVP_ISR_ADC = 9;
    localparam int IVP_ISR_TRANSCEIVER_OVERTEMP_IRQ = 10;
    localparam int IVP_ISR_HIGH_SIDE_OVERTEMP_IRQ = 11;
    localparam int IVP_ISR_LOW_SIDE_OVERTEMP_IRQ = 12;
    localparam int IVP_ISR_HOT = 13;

    ////////////////////////////////////////////////////////////////////////////////
    // edge-latched source cells
    localparam int IVP_CELL_LVI = 0;
    localparam int IVP_CELL_HTI = 1;
    localparam int IVP_CELL_LBI = 2;
    localparam int IVP_CELL_HVI = 3;
    localparam int IVP_CELL_REGULATOR_OVERVOLTAGE_IRQ = 4;
    localparam int IVP_CELL_TRANSCEIVER_OVERTEMP_IRQ = 5;
    localparam int IVP_CELL_HIGH_SIDE_OVERTEMP_IRQ = 6;
    localparam int IVP_CELL_LOW_SIDE_OVERTEMP_IRQ = 7;
    localparam int IVP_CELL_HOT = 8;
    localparam logic [IVP_NUM_CELLS-1:0] IVP_VSR_CELLS = 9'h01F;

endpackage : ivp_pkg

// ### verilog/ivp_edge_src.sv
// one edge-latched interrupt source with read acknowledge
module ivp_edge_src (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // asynchronous condition, same-clock acknowledge
    input wire logic cond,
    input wire logic ack,
    // state
    output logic pend,
    output logic rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic pend;
    } ivp_src_state_t;

    ivp_src_state_t st_r;
    ivp_src_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // a persisting condition cannot refire: only a fresh rising edge sets pending
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = cond;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        st_nxt.pend = rise | (st_r.pend & ~ack); // set wins over clear
    end

    assign rise = st_r.s2 & ~st_r.prev;
    assign pend = st_r.pend;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    refire_edge_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(st_r.pend) |-> $past(st_r.s2) && !$past(st_r.prev))
        else $error("pending set without a fresh condition edge");

endmodule : ivp_edge_src

// ### verilog/ivp_prio_enc.sv
// fixed priority encoder producing the doubled vector code
module ivp_prio_enc #(
    parameter int NUM = 18
) (
    // pending flags, bit 0 highest priority
    input wire logic [NUM-1:0] pend,
    // doubled source number, zero when idle
    output logic [5:0] code
);

    ////////////////////////////////////////////////////////////////////////////////
    // scan from lowest to highest so the highest pending one wins
    always_comb
    begin
        code = 6'h00;
        for (int i = NUM - 1; i >= 0; i--)
        begin
            if (pend[i])
                code = 6'((i + 1) * 2);
        end
    end

endmodule : ivp_prio_enc

// ### dv/ivp_host_model.sv
// host-side model of the die link master issuing register reads
module ivp_host_model (
    // system clock, used only to pace the link
    input wire logic clk,
    // link pins driven by the host
    output logic link_clk,
    output logic link_rd,
    output logic [ivp_pkg::IVP_ADDR_W-1:0] link_addr,
    // answer from the device
    input wire logic [ivp_pkg::IVP_DATA_W-1:0] link_rd_data,
    input wire logic link_rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////////
    // idle pins: link clock parked low, it only runs inside a frame
    initial
    begin
        link_clk = 1'b0;
        link_rd = 1'b0;
        link_addr = 10'h000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one read frame of 400 ns, 250 ns high and 150 ns low; the request is
    // held for the whole high phase so the answer is never released early
    task automatic read(input logic [9:0] addr, output logic [15:0] data, output logic ok);
        ok = 1'b0;
        data = 16'h0000;
        @(negedge clk);
        link_rd = 1'b1;
        link_addr = addr;
        @(negedge clk);
        link_clk = 1'b1;
        // valid is a one-cycle pulse: look mid-cycle, where it has settled
        repeat (5)
        begin
            @(negedge clk);
            if (link_rd_valid === 1'b1)
            begin
                ok = 1'b1;
                data = link_rd_data;
            end
        end
        link_clk = 1'b0;
        link_rd = 1'b0;
        link_addr = ~addr; // released lines must not keep the last address
        @(negedge clk);
    endtask : read
endmodule : ivp_host_model

// ### dv/ivp_irq_top_bench.sv
// self-checking bench for the interrupt vector, mirror and acknowledge block
module ivp_irq_top_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic rstn;
    logic stop_mode;
    logic wake_event;
    logic [17:0] src;
    logic link_clk;
    logic link_rd;
    logic [ivp_pkg::IVP_ADDR_W-1:0] link_addr;
    logic [ivp_pkg::IVP_DATA_W-1:0] link_rd_data;
    logic link_rd_valid;
    logic irq;
    int n_errors;
    int compares;
    int i;

    ////////////////////////////////////////////////////////////////////////////////
    // sources are kept in priority order, bit 0 ranks highest
    ivp_irq_top dut (
        .clk(clk),
        .rstn(rstn),
        .link_clk(link_clk),
        .link_rd(link_rd),
        .link_addr(link_addr),
        .link_rd_data(link_rd_data),
        .link_rd_valid(link_rd_valid),
        .die_link_interrupt_out(irq),
        .stop_mode(stop_mode),
        .wake_event(wake_event),
        .regulator_low_voltage_irq(src[0]),
        .regulator_high_temp_irq(src[1]),
        .low_battery_irq(src[2]),
        .high_voltage_irq(src[16]),
        .regulator_overvoltage_irq(src[17]),
        .transceiver_overtemp_irq(src[12]),
        .high_side_overtemp_irq(src[13]),
        .low_side_overtemp_irq(src[14]),
        .sensor_supply_overtemp_irq(src[15]),
        .timer_channel_irq(src[6:3]),
        .timer_overflow_irq(src[7]),
        .sci_error_irq(src[8]),
        .sci_transmit_irq(src[9]),
        .sci_receive_irq(src[10]),
        .converter_sequence_done_irq(src[11])
    );

    ivp_host_model host (
        .clk(clk),
        .link_clk(link_clk),
        .link_rd(link_rd),
        .link_addr(link_addr),
        .link_rd_data(link_rd_data),
        .link_rd_valid(link_rd_valid)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // 20 MHz system clock
    always #25 clk = ~clk;

    // verdict and end of run
    task automatic report_and_stop;
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // read over the link and compare the whole 16-bit answer
    task automatic cmp_read(input logic [9:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        host.read(a, d, ok);
        compares++;
        if (ok !== 1'b1 || d !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: read %h gave %h, want %h", $time, a, d, e);
        end
    endtask : cmp_read

    // interrupt line is looked at once its inputs have passed the synchronisers
    task automatic cmp_irq(input logic e);
        repeat (6) @(negedge clk);
        compares++;
        if (irq !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: interrupt line %b, want %b", $time, irq, e);
        end
    endtask : cmp_irq

    // change the source levels off the sampling edge and let them settle
    task automatic drive(input logic [17:0] s);
        @(negedge clk);
        src = s;
        repeat (6) @(negedge clk);
    endtask : drive

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the tests take well under a tenth of this span
    initial
    begin
        #400000;
        n_errors++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        stop_mode = 1'b0;
        wake_event = 1'b0;
        src = 18'h00000;
        n_errors = 0;
        compares = 0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        cmp_read(10'h202, 16'h0000);
        cmp_read(10'h200, 16'h0000);
        cmp_irq(1'b0);
        // raise sources from the lowest rank up; each newcomer must win
        for (i = 17; i >= 0; i--)
        begin
            drive(src | (18'h00001 << i));
            cmp_read(i[0] ? 10'h302 : 10'h202, 16'(2 * (i + 1)));
        end
        cmp_irq(1'b1);
        cmp_read(10'h300, 16'h3FFF);
        cmp_read(10'h301, 16'h003F);
        cmp_read(10'h202, 16'h0002);
        cmp_read(10'h210, 16'h001F);
        cmp_read(10'h202, 16'h0008);
        // owning modules drop their own flags
        drive(src & 18'h3F007);
        cmp_read(10'h202, 16'h001A);
        cmp_read(10'h211, 16'h0001);
        cmp_read(10'h211, 16'h0000);
        cmp_read(10'h202, 16'h001C);
        cmp_read(10'h212, 16'h0001);
        cmp_read(10'h302, 16'h001E);
        cmp_read(10'h213, 16'h0001);
        cmp_read(10'h202, 16'h0020);
        cmp_read(10'h214, 16'h0001);
        cmp_read(10'h202, 16'h0000);
        cmp_read(10'h200, 16'h0000);
        cmp_irq(1'b0);
        // low voltage goes away and returns: only it fires again
        drive(src & ~18'h00001);
        drive(src | 18'h00001);
        cmp_read(10'h202, 16'h0002);
        cmp_read(10'h210, 16'h0001);
        // unmapped offset and an address outside both windows read zero
        cmp_read(10'h2FF, 16'h0000);
        cmp_read(10'h100, 16'h0000);
        // stop mode hides the pending source until a wake-up
        drive(src & ~18'h00004);
        stop_mode = 1'b1;
        drive(src | 18'h00004);
        cmp_irq(1'b0);
        wake_event = 1'b1;
        @(negedge clk);
        wake_event = 1'b0;
        cmp_irq(1'b1);
        cmp_read(10'h200, 16'h0001);
        cmp_irq(1'b0);
        stop_mode = 1'b0;
        cmp_irq(1'b1);
        cmp_read(10'h210, 16'h0004);
        cmp_irq(1'b0);
        report_and_stop();
    end
endmodule : ivp_irq_top_bench
